// file: hdl/tals_pkg.sv
// Shared constants, types and register map for the tape sequencer
package tals_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned POSTROLL_S   = 3;
  localparam int unsigned POSTROLL_CYC = CLK_HZ * POSTROLL_S;
  localparam int unsigned BLINK_MS     = 250;
  localparam int unsigned BLINK_CYC    = (CLK_HZ / 1000) * BLINK_MS;
  localparam int unsigned POST_W       = 26;
  localparam int unsigned BLINK_W      = 23;

  // Tape counter
  localparam int unsigned CNT_W = 16;
  typedef logic [CNT_W-1:0] tals_cnt_t;
  localparam tals_cnt_t CNT_ZERO = 16'h0000;

  // APB register map (byte addresses)
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] A_MARK1  = 8'h00;
  localparam logic [7:0] A_MARK2  = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_START  = 8'h0C;
  localparam logic [7:0] A_IN     = 8'h10;
  localparam logic [7:0] A_OUT    = 8'h14;
  localparam logic [7:0] A_CTRL   = 8'h18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int unsigned CTRL_FOOT_EN = 0;

  // Operator buttons, one bit each
  typedef struct packed {
    logic play, stop, ffwd, rew, seek1, seek2, zero;
    logic rpt, rehearse, autop, clr, mark1, mark2, foot;
  } tals_btn_s;
  localparam int unsigned BTN_W = 14;

  typedef enum logic [2:0] {
    MOT_STOP = 3'h0, MOT_PLAY = 3'h1, MOT_FFWD = 3'h2,
    MOT_REW = 3'h3, MOT_SLOW_REV = 3'h4
  } tals_mot_e;

  typedef enum logic [1:0] {
    LBL_NONE = 2'h0, LBL_START = 2'h1, LBL_IN = 2'h2, LBL_OUT = 2'h3
  } tals_lbl_e;

  typedef struct packed {
    tals_lbl_e label;
    logic      flash;
    tals_cnt_t value;
  } tals_disp_s;

  typedef enum logic [9:0] {
    S_IDLE = 10'h001, S_PLAY = 10'h002, S_MAN  = 10'h004, S_WIND = 10'h008,
    S_SLOW = 10'h010, S_LPRE = 10'h020, S_LIN  = 10'h040, S_LOUT = 10'h080,
    S_POST = 10'h100, S_RWND = 10'h200
  } tals_state_e;
endpackage

// file: hdl/tals_sequencer.sv
// Transport sequencer: locate, repeat loop, rehearsal and auto punch
// What this block does
// [R1] Overshot locate backs up slowly, then stops/plays
// [R2] Play during slow return blocks; stop frees
// [R3] Return to zero winds to counter zero
// [R4] Loop bounds are lower and higher memo
// [R5] Repeat plays to high, rewinds to low
// [R6] Play from below loop joins repeating
// [R7] Beyond loop, repeat indicator blinks
// [R8] Repeat toggles only by its own button
// [R9] Set mode captures start, in, out
// [R10] Rehearsal switches monitor, never records
// [R11] Ready mode: play starts rehearsal loop
// [R12] Play presses capture points, show labelled value
// [R13] Postroll, then rewind to flashing start
// [R14] Auto ignored until all points set
// [R15] Loop display: in, then out, relabelled
// [R16] Auto: play or footswitch runs punch sequence
// [R17] Clear leaves rehearsal or auto only
// [R18] All compares use the displayed counter
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module tals_sequencer
  import tals_pkg::*;
#(
  parameter int unsigned POSTROLL_CYCLES = POSTROLL_CYC,
  parameter int unsigned BLINK_CYCLES    = BLINK_CYC
) (
  input  wire logic              core_clk_in,
  input  wire logic              resetn_in,
  input  wire tals_btn_s         buttons_in,
  input  wire tals_cnt_t         tape_count_in,
  input  wire logic [APB_AW-1:0] paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output tals_mot_e              motion_out,
  output logic                   monitor_source_out,
  output logic                   record_out,
  output logic                   repeat_led_out,
  output logic                   rehearsal_mode_out,
  output logic                   auto_led_out,
  output tals_cnt_t              counter_disp_out,
  output tals_disp_s             memory_disp_out
);
  localparam logic [POST_W-1:0]  POST_LAST  = POST_W'(POSTROLL_CYCLES - 1);
  localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_CYCLES - 1);

  function automatic tals_cnt_t lower(input tals_cnt_t a, input tals_cnt_t b);
    lower = (a < b) ? a : b;
  endfunction
  function automatic tals_cnt_t upper(input tals_cnt_t a, input tals_cnt_t b);
    upper = (a < b) ? b : a;
  endfunction

  // Pin synchronisers; a level counts once stages two and three agree
  tals_btn_s b1_reg, b2_reg, b3_reg, bacc_reg;
  tals_cnt_t c1_reg, c2_reg, c3_reg, pos_reg, prev_reg;
  logic [BTN_W-1:0] btn_next;
  tals_btn_s  press;
  tals_cnt_t  pos_next;
  assign btn_next = (b2_reg & ~(b2_reg ^ b3_reg)) | (bacc_reg & (b2_reg ^ b3_reg));
  assign press    = btn_next & ~bacc_reg;
  assign pos_next = (c2_reg == c3_reg) ? c2_reg : pos_reg;

  always_ff @(posedge core_clk_in) begin
    b1_reg <= buttons_in;
    b2_reg <= b1_reg;
    b3_reg <= b2_reg;
    c1_reg <= tape_count_in;
    c2_reg <= c1_reg;
    c3_reg <= c2_reg;
    if (!resetn_in) begin
      bacc_reg <= '0;
      pos_reg  <= CNT_ZERO;
      prev_reg <= CNT_ZERO;
    end else begin
      bacc_reg <= btn_next;
      pos_reg  <= pos_next;
      prev_reg <= pos_reg;
    end
  end

  // Sequencer state
  tals_state_e st_reg, st_next;
  tals_cnt_t   tgt_reg, tgt_next, mark1_reg, mark1_next, mark2_reg, mark2_next;
  tals_cnt_t   pstart_reg, pstart_next, pin_reg, pin_next, pout_reg, pout_next;
  tals_cnt_t   val_reg, val_next;
  tals_lbl_e   lbl_reg, lbl_next;
  logic [2:0]  pts_reg, pts_next;
  logic [1:0]  idx_reg, idx_next;
  logic [POST_W-1:0] post_reg, post_next;
  logic pend_reg, pend_next, blk_reg, blk_next, rpt_reg, rpt_next;
  logic setm_reg, setm_next, rdy_reg, rdy_next, auto_reg, auto_next;
  logic wfwd_reg, wfwd_next, mdir_reg, mdir_next;
  logic [31:0] ctrl_reg;
  logic [BLINK_W-1:0] blink_cnt_reg;
  logic blink_reg;

  // Loop bounds from the memos, crossing from the displayed counter, then key and bus decode
  tals_cnt_t loop_lo, loop_hi;
  logic cross_hi, go, in_seq, any_mode, apb_wr, apb_setup, addr_ok;
  assign loop_lo  = lower(mark1_reg, mark2_reg); // [R4] [R18]
  assign loop_hi  = upper(mark1_reg, mark2_reg); // [R4]
  assign cross_hi = (prev_reg < loop_hi) && (pos_reg >= loop_hi); // [R6]
  assign any_mode = setm_reg | rdy_reg | auto_reg;
  // Footswitch acts like play only in the punch modes
  assign go       = press.play | (press.foot & any_mode & ctrl_reg[CTRL_FOOT_EN]);
  assign in_seq   = st_reg inside {S_LPRE, S_LIN, S_LOUT, S_POST, S_RWND};
  assign apb_wr   = psel_in & penable_in & pwrite_in;
  assign apb_setup = psel_in & ~penable_in;
  assign addr_ok  = paddr_in inside {A_MARK1, A_MARK2, A_STATUS, A_START, A_IN,
                                     A_OUT, A_CTRL};

  // Next-state logic; stop has top priority, then clear, then mode keys
  always_comb begin
    st_next = st_reg;  tgt_next = tgt_reg;  pend_next = pend_reg;
    blk_next = blk_reg;  setm_next = setm_reg;  rdy_next = rdy_reg;
    auto_next = auto_reg;  idx_next = idx_reg;  pts_next = pts_reg;
    pstart_next = pstart_reg;  pin_next = pin_reg;  pout_next = pout_reg;
    val_next = val_reg;  lbl_next = lbl_reg;  post_next = post_reg;
    wfwd_next = wfwd_reg;  mdir_next = mdir_reg;
    rpt_next = rpt_reg ^ press.rpt; // [R8]
    mark1_next = press.mark1 ? pos_reg : mark1_reg;
    mark2_next = press.mark2 ? pos_reg : mark2_reg;
    if (apb_wr && paddr_in == A_MARK1) mark1_next = pwdata_in[CNT_W-1:0];
    if (apb_wr && paddr_in == A_MARK2) mark2_next = pwdata_in[CNT_W-1:0];
    if (press.stop) begin
      st_next = S_IDLE; // [R2]
      pend_next = 1'b0;
      blk_next = 1'b0; // [R2]
    end else if (press.clr && any_mode) begin
      setm_next = 1'b0; // [R17]
      rdy_next = 1'b0;
      auto_next = 1'b0;
      lbl_next = LBL_NONE;
      if (in_seq) st_next = S_IDLE;
    end else if (press.rehearse && !in_seq) begin
      setm_next = 1'b1; // [R9]
      rdy_next = 1'b0;
      auto_next = 1'b0;
      idx_next = 2'h0;
      pts_next = 3'h0;
      lbl_next = LBL_NONE;
    end else if (press.autop) begin
      if (&pts_reg && !in_seq) begin
        auto_next = 1'b1; // [R14]
        setm_next = 1'b0;
      end
    end else if (press.ffwd || press.rew) begin
      st_next = S_MAN;
      mdir_next = press.ffwd;
      pend_next = 1'b0;
      blk_next = 1'b0;
    end else if (press.seek1 || press.seek2 || press.zero) begin
      st_next = S_WIND;
      tgt_next = press.zero ? CNT_ZERO : (press.seek1 ? mark1_reg : mark2_reg); // [R3]
      wfwd_next = press.zero ? (pos_reg < CNT_ZERO) :
                  (pos_reg < (press.seek1 ? mark1_reg : mark2_reg)); // [R3]
      val_next = tgt_next;
      pend_next = 1'b0;
      blk_next = 1'b0;
    end else if (go && setm_reg && (st_reg == S_IDLE || st_reg == S_PLAY)) begin
      val_next = pos_reg; // [R12]
      idx_next = idx_reg + 2'h1;
      if (idx_reg == 2'h0) begin
        pstart_next = pos_reg; // [R9]
        pts_next[0] = 1'b1;
        lbl_next = LBL_START;
        st_next = S_PLAY;
      end else if (idx_reg == 2'h1) begin
        pin_next = pos_reg; // [R9]
        pts_next[1] = 1'b1;
        lbl_next = LBL_IN;
      end else begin
        pout_next = pos_reg; // [R9]
        pts_next[2] = 1'b1;
        lbl_next = LBL_OUT;
        setm_next = 1'b0;
        st_next = S_POST; // [R13]
        post_next = '0;
      end
    end else begin
      unique case (st_reg)
        S_IDLE: begin
          if (go && (rdy_reg || auto_reg) && &pts_reg) begin
            st_next = S_LPRE; // [R11] [R16]
            lbl_next = LBL_START; // [R15]
            val_next = pin_reg;
          end else if (press.play) begin
            st_next = S_PLAY;
          end
        end
        S_PLAY: begin
          if (rpt_reg && cross_hi) begin
            st_next = S_WIND; // [R5] [R6]
            tgt_next = loop_lo;
            wfwd_next = 1'b0;
            pend_next = 1'b1;
          end
        end
        S_MAN: begin
          if (press.play) st_next = S_PLAY;
        end
        S_WIND: begin
          if (press.play) pend_next = 1'b1;
          if (pos_reg == tgt_reg) begin
            st_next = (pend_next ? S_PLAY : S_IDLE); // [R1]
            pend_next = 1'b0;
          end else if (wfwd_reg == (pos_reg > tgt_reg)) begin
            st_next = S_SLOW; // [R1]
          end
        end
        S_SLOW: begin
          if (press.play) begin
            blk_next = 1'b1; // [R2]
            pend_next = 1'b1;
          end else if (!blk_reg && (wfwd_reg ? (pos_reg <= tgt_reg)
                                             : (pos_reg >= tgt_reg))) begin
            st_next = pend_reg ? S_PLAY : S_IDLE; // [R1]
            pend_next = 1'b0;
          end
        end
        S_LPRE: begin
          if (pos_reg >= pin_reg) begin
            st_next = S_LIN; // [R10]
            lbl_next = LBL_IN; // [R15]
            val_next = pout_reg;
          end
        end
        S_LIN: begin
          if (pos_reg >= pout_reg) begin
            st_next = S_LOUT; // [R10]
            lbl_next = LBL_OUT; // [R15]
          end
        end
        S_LOUT: begin
          st_next = S_POST; // [R16]
          post_next = '0;
        end
        S_POST: begin
          if (post_reg == POST_LAST) begin
            st_next = S_RWND; // [R13]
            val_next = pstart_reg;
            lbl_next = LBL_START;
          end else begin
            post_next = post_reg + 1'b1;
          end
        end
        S_RWND: begin
          if (pos_reg == pstart_reg) begin
            st_next = S_IDLE; // [R13]
            rdy_next = ~auto_reg; // [R11]
          end
        end
        default: st_next = S_IDLE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_reg <= S_IDLE;  tgt_reg <= CNT_ZERO;  pend_reg <= 1'b0;  blk_reg <= 1'b0;
      rpt_reg <= 1'b0;  setm_reg <= 1'b0;  rdy_reg <= 1'b0;  auto_reg <= 1'b0;
      idx_reg <= 2'h0;  pts_reg <= 3'h0;  post_reg <= '0;
      pstart_reg <= CNT_ZERO;  pin_reg <= CNT_ZERO;  pout_reg <= CNT_ZERO;
      mark1_reg <= CNT_ZERO;  mark2_reg <= CNT_ZERO;  val_reg <= CNT_ZERO;
      lbl_reg <= LBL_NONE;  wfwd_reg <= 1'b0;  mdir_reg <= 1'b0;
    end else begin
      st_reg <= st_next;  tgt_reg <= tgt_next;  pend_reg <= pend_next;
      blk_reg <= blk_next;  rpt_reg <= rpt_next;  setm_reg <= setm_next;
      rdy_reg <= rdy_next;  auto_reg <= auto_next;  idx_reg <= idx_next;
      pts_reg <= pts_next;  post_reg <= post_next;  pstart_reg <= pstart_next;
      pin_reg <= pin_next;  pout_reg <= pout_next;  mark1_reg <= mark1_next;
      mark2_reg <= mark2_next;  val_reg <= val_next;  lbl_reg <= lbl_next;
      wfwd_reg <= wfwd_next;  mdir_reg <= mdir_next;
    end
  end

  // Blink divider shared by every flashing indicator
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == BLINK_LAST) begin
      blink_cnt_reg <= '0;
      blink_reg <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end

  // Read data is latched in the setup phase so the access phase needs no wait
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0000_0000;
      ctrl_reg <= CTRL_RST;
    end else begin
      if (apb_wr && paddr_in == A_CTRL) ctrl_reg <= pwdata_in;
      if (apb_setup) begin
        unique case (paddr_in)
          A_MARK1:  prdata_out <= {16'h0000, mark1_reg};
          A_MARK2:  prdata_out <= {16'h0000, mark2_reg};
          A_STATUS: prdata_out <= {11'h000, auto_reg, rdy_reg, setm_reg, rpt_reg,
                                   blk_reg, pend_reg, pts_reg, idx_reg, st_reg};
          A_START:  prdata_out <= {16'h0000, pstart_reg};
          A_IN:     prdata_out <= {16'h0000, pin_reg};
          A_OUT:    prdata_out <= {16'h0000, pout_reg};
          A_CTRL:   prdata_out <= ctrl_reg;
          default:  prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~addr_ok;

  // Transport outputs; rehearsal never records; an overshot rewind creeps back, no hunting
  assign motion_out =
    (st_reg inside {S_PLAY, S_LPRE, S_LIN, S_LOUT, S_POST}) ? MOT_PLAY :
    (st_reg == S_MAN)  ? (mdir_reg ? MOT_FFWD : MOT_REW) :
    (st_reg == S_WIND) ? (wfwd_reg ? MOT_FFWD : MOT_REW) : // [R3]
    (st_reg == S_SLOW) ? (blk_reg ? MOT_STOP :
                          (wfwd_reg ? MOT_SLOW_REV : MOT_PLAY)) : // [R1]
    (st_reg == S_RWND) ? ((pos_reg > pstart_reg) ? MOT_REW : MOT_PLAY) : MOT_STOP; // [R13]
  assign monitor_source_out = (st_reg == S_LIN); // [R10]
  assign record_out         = (st_reg == S_LIN) & auto_reg; // [R10] [R16]
  assign repeat_led_out     = rpt_reg & ((pos_reg > loop_hi) ? blink_reg : 1'b1); // [R7]
  assign rehearsal_mode_out = rdy_reg | (setm_reg & blink_reg);
  assign auto_led_out       = auto_reg;
  assign counter_disp_out   = pos_reg; // [R18]
  assign memory_disp_out.label = lbl_reg;
  assign memory_disp_out.value = val_reg;
  assign memory_disp_out.flash = (st_reg inside {S_WIND, S_RWND}) & blink_reg; // [R13]

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_post_done;
    st_reg == S_POST && post_reg == POST_LAST && press == '0;
  endsequence
  sequence s_punch_in;
    st_reg == S_LPRE && pos_reg >= pin_reg && press == '0;
  endsequence

  a_stop_frees: assert property (press.stop |=> st_reg == S_IDLE && !blk_reg) // [R2]
    else $error("stop did not free the transport");
  a_repeat_hold: assert property (!press.rpt |=> rpt_reg == $past(rpt_reg)) // [R8]
    else $error("repeat changed without its button");
  a_loop_order: assert property (loop_lo <= loop_hi) // [R4]
    else $error("loop bounds out of order");
  a_repeat_wrap: assert property (st_reg == S_PLAY && rpt_reg && cross_hi && press == '0
    |=> st_reg == S_WIND && tgt_reg == loop_lo && pend_reg) // [R5]
    else $error("repeat loop did not rewind to lower point");
  a_rehearse_no_rec: assert property (record_out |-> auto_reg && monitor_source_out) // [R10]
    else $error("record active outside auto punch");
  a_auto_guard: assert property (!auto_reg && pts_reg != 3'h7 |=> !auto_reg) // [R14]
    else $error("auto accepted before points set");
  a_clear_mode: assert property (press.clr && !press.stop && any_mode
    |=> !setm_reg && !rdy_reg && !auto_reg) // [R17]
    else $error("clear left a punch mode active");
  a_post_rewind: assert property (s_post_done |=> st_reg == S_RWND
    && val_reg == pstart_reg && lbl_reg == LBL_START) // [R13]
    else $error("postroll end did not rewind to start");
  a_punch_show: assert property (s_punch_in |=> st_reg == S_LIN
    && lbl_reg == LBL_IN && val_reg == pout_reg ##1 monitor_source_out) // [R15]
    else $error("punch-in display or monitor wrong");
  a_blink_out: assert property (rpt_reg && pos_reg > loop_hi
    |-> repeat_led_out == blink_reg) // [R7]
    else $error("repeat indicator not blinking beyond loop");
endmodule

// file: verif/tals_tape_model.sv
// Tape transport model: moves the position counter as the motors are commanded
`timescale 1ns/100ps
module tals_tape_model
  import tals_pkg::*;
(
  input  wire logic      core_clk_in,
  input  wire logic      load_in,
  input  wire tals_cnt_t load_val_in,
  input  wire tals_mot_e motion_in,
  output tals_cnt_t      tape_count_out
);
  logic [2:0] div_reg;

  // One step every 8 clocks keeps the tape slower than the input sync lag;
  // a wind step of 4 lets a locate jump past a target that is not a multiple of 4
  always_ff @(posedge core_clk_in) begin
    div_reg <= load_in ? 3'h0 : div_reg + 3'h1;
    if (load_in) begin
      tape_count_out <= load_val_in;
    end else if (div_reg == 3'h7) begin
      case (motion_in)
        MOT_PLAY:     tape_count_out <= tape_count_out + 16'h0001;
        MOT_FFWD:     tape_count_out <= tape_count_out + 16'h0004;
        MOT_REW:      tape_count_out <= tape_count_out - 16'h0004;
        MOT_SLOW_REV: tape_count_out <= tape_count_out - 16'h0001;
        default:      tape_count_out <= tape_count_out;
      endcase
    end
  end
endmodule

// file: verif/test_tape_autolocate_punch_sequencer.sv
// Self-checking bench for the tape autolocate and punch sequencer
`timescale 1ns/100ps
module test_tape_autolocate_punch_sequencer
  import tals_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } tals_row_s;
  localparam int B_PLAY = 13, B_STOP = 12, B_FFWD = 11, B_REW = 10, B_SEEK1 = 9;
  localparam int B_ZERO = 7, B_REPEAT = 6, B_REHEARSE = 5, B_AUTO = 4, B_CLEAR = 3;
  localparam int B_MARK2 = 1, B_FOOT = 0;
  logic        clk, rstn, load, psel, penable, pwrite, pready, pslverr, e;
  logic        mon, rec, rled, rmode, aled;
  logic [13:0] btn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  tals_cnt_t   tape, ldv, cdisp, st, pin, pout;
  tals_mot_e   motion;
  tals_disp_s  mdisp;
  int          bad_count, cmp_count, ones;
  // Register rows: address, write, data, expected read data, expected error
  tals_row_s   rows [9] = '{
    '{A_CTRL, 1'h0, 32'h0, CTRL_RST, 1'h0}, '{A_MARK1, 1'h1, 32'h42, 32'h0, 1'h0},
    '{A_MARK1, 1'h0, 32'h0, 32'h42, 1'h0}, '{A_MARK2, 1'h1, 32'hA5, 32'h0, 1'h0},
    '{A_MARK2, 1'h0, 32'h0, 32'hA5, 1'h0}, '{A_START, 1'h1, 32'h1234, 32'h0, 1'h0},
    '{A_START, 1'h0, 32'h0, 32'h0, 1'h0}, '{8'h1C, 1'h1, 32'h1, 32'h0, 1'h1},
    '{8'h1C, 1'h0, 32'h0, 32'h0, 1'h1}};

  // Design with short postroll and blink so the run stays brief
  tals_sequencer #(.POSTROLL_CYCLES(20), .BLINK_CYCLES(4)) DUT (
    .core_clk_in(clk), .resetn_in(rstn), .buttons_in(tals_btn_s'(btn)),
    .tape_count_in(tape), .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .motion_out(motion), .monitor_source_out(mon),
    .record_out(rec), .repeat_led_out(rled), .rehearsal_mode_out(rmode),
    .auto_led_out(aled), .counter_disp_out(cdisp), .memory_disp_out(mdisp));
  tals_tape_model tape_model (.core_clk_in(clk), .load_in(load), .load_val_in(ldv),
    .motion_in(motion), .tape_count_out(tape));

  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      bad_count++;
    end
  endtask

  // APB transfer: request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      chk("pready", 32'h1, 32'(pready));
      end_sim();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'h0, 32'h0, q, e);
  endtask

  // Button held long enough for the input synchroniser, result settled on return
  task automatic press(input int i);
    @(posedge clk);
    btn[i] <= 1'h1;
    tick(5);
    btn[i] <= 1'h0;
    tick(4);
    @(negedge clk);
  endtask

  task automatic ld(input tals_cnt_t v);
    @(posedge clk);
    load <= 1'h1;
    ldv <= v;
    @(posedge clk);
    load <= 1'h0;
    tick(6);
  endtask

  // Bounded wait on motion (0), monitor source (1) or record (2)
  task automatic wt(input int s, input logic [31:0] v);
    int n;
    logic [31:0] x;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      x = (s == 0) ? 32'(motion) : (s == 1) ? 32'(mon) : 32'(rec);
    end while (x !== v && n < 4000);
    if (n >= 4000) begin
      chk("wait", v, x);
      end_sim();
    end
  endtask

  task automatic blink(input int s);
    ones = 0;
    repeat (16) begin
      @(negedge clk);
      ones += (s == 0) ? int'(rled) : (s == 1) ? int'(rmode) : int'(mdisp.flash);
    end
  endtask

  // Main sequence: reset, register rows, then transport scenarios
  initial begin
    bad_count = 0;
    cmp_count = 0;
    rstn = 1'h0;
    btn = 14'h0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load = 1'h1;
    ldv = 16'h0010;
    tick(4);
    rstn <= 1'h1;
    load <= 1'h0;
    @(negedge clk);
    chk("motion", 32'(MOT_STOP), 32'(motion));
    chk("leds", 32'h0, 32'({rled, rmode, aled, rec, mon, mdisp}));
    chk("pready", 32'h1, 32'(pready));
    tick(5);
    @(negedge clk);
    chk("counter", 32'h10, 32'(cdisp));
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d, q, e);
      if (!rows[i].w) chk("rdata", rows[i].q, q);
      chk("slverr", 32'(rows[i].e), 32'(e));
    end
    // Forward locate overshoots 0x42 with play pending
    press(B_SEEK1);
    chk("motion", 32'(MOT_FFWD), 32'(motion));
    press(B_PLAY);
    wt(0, 32'(MOT_SLOW_REV));
    wt(0, 32'(MOT_PLAY));
    chk("target", 32'h42, 32'(cdisp));
    press(B_STOP);
    // Play in the slow return blocks; stop frees the transport
    ld(16'h0010);
    press(B_SEEK1);
    wt(0, 32'(MOT_SLOW_REV));
    press(B_PLAY);
    chk("motion", 32'(MOT_STOP), 32'(motion));
    rd(A_STATUS);
    chk("blocked", 32'h1, 32'(q[16]));
    press(B_STOP);
    rd(A_STATUS);
    chk("freed", 32'h1, 32'({q[16], q[9:0]}));
    ld(16'h0040);
    press(B_ZERO);
    chk("motion", 32'(MOT_REW), 32'(motion));
    wt(0, 32'(MOT_STOP));
    chk("zero", 32'h0, 32'(cdisp));
    // Repeat loop with the higher point stored first
    apb(A_MARK1, 1'h1, 32'h60, q, e);
    apb(A_MARK2, 1'h1, 32'h50, q, e);
    ld(16'h0054);
    press(B_REPEAT);
    chk("repeat_led", 32'h1, 32'(rled));
    press(B_PLAY);
    wt(0, 32'(MOT_REW));
    chk("loop_hi", 32'h60, 32'(cdisp));
    wt(0, 32'(MOT_PLAY));
    chk("loop_lo", 32'h50, 32'(cdisp));
    press(B_REW);
    tick(40);
    press(B_PLAY);
    wt(0, 32'(MOT_REW));
    chk("loop_hi", 32'h60, 32'(cdisp));
    wt(0, 32'(MOT_PLAY));
    press(B_FFWD);
    tick(80);
    blink(0);
    chk("rpt_blink", 32'h1, 32'(ones > 0 && ones < 16));
    press(B_STOP);
    rd(A_STATUS);
    chk("repeat_on", 32'h1, 32'(q[17]));
    press(B_REPEAT);
    chk("repeat_led", 32'h0, 32'(rled));
    // Auto refused with no points; clear does nothing in normal mode
    ld(16'h0100);
    press(B_MARK2);
    rd(A_MARK2);
    chk("mark2", 32'h100, q);
    press(B_AUTO);
    chk("auto_led", 32'h0, 32'(aled));
    press(B_CLEAR);
    rd(A_STATUS);
    chk("modes", 32'h1, 32'({q[20:18], q[9:0]}));
    // Rehearsal set: three play presses capture the points
    press(B_REHEARSE);
    blink(1);
    chk("set_blink", 32'h1, 32'(ones > 0 && ones < 16));
    press(B_PLAY);
    chk("start", 32'({LBL_START, MOT_PLAY}), 32'({mdisp.label, motion}));
    tick(40);
    press(B_PLAY);
    chk("label", 32'(LBL_IN), 32'(mdisp.label));
    tick(40);
    press(B_PLAY);
    chk("label", 32'(LBL_OUT), 32'(mdisp.label));
    wt(0, 32'(MOT_REW));
    blink(2);
    chk("flash", 32'h1, 32'(ones > 0 && ones < 16));
    chk("flash_lbl", 32'(LBL_START), 32'(mdisp.label));
    wt(0, 32'(MOT_STOP));
    rd(A_START);
    st = q[15:0];
    rd(A_IN);
    pin = q[15:0];
    rd(A_OUT);
    pout = q[15:0];
    chk("order", 32'h1, 32'(st < pin && pin < pout));
    chk("home", 32'(st), 32'(cdisp));
    chk("ready", 32'h1, 32'(rmode));
    // Rehearsal loop: display sequence and monitor switching, no recording
    press(B_PLAY);
    chk("pre", 32'({LBL_START, pin}), 32'({mdisp.label, mdisp.value}));
    wt(1, 32'h1);
    chk("in_disp", 32'({LBL_IN, pout}), 32'({mdisp.label, mdisp.value}));
    chk("in_pos", 32'({pin, 1'h0}), 32'({cdisp, rec}));
    wt(1, 32'h0);
    chk("out_disp", 32'({LBL_OUT, pout}), 32'({mdisp.label, mdisp.value}));
    chk("out_pos", 32'({pout, 1'h0}), 32'({cdisp, rec}));
    wt(0, 32'(MOT_STOP));
    // Footswitch ignored while its enable bit is clear
    apb(A_CTRL, 1'h1, 32'h0, q, e);
    press(B_FOOT);
    chk("foot_off", 32'(MOT_STOP), 32'(motion));
    apb(A_CTRL, 1'h1, 32'h1, q, e);
    // Auto punch started from the footswitch records between the points
    press(B_AUTO);
    chk("auto_led", 32'h1, 32'(aled));
    press(B_FOOT);
    wt(2, 32'h1);
    chk("punch_in", 32'({pin, 1'h1}), 32'({cdisp, mon}));
    wt(2, 32'h0);
    chk("punch_out", 32'({pout, 1'h0}), 32'({cdisp, mon}));
    wt(0, 32'(MOT_REW));
    wt(0, 32'(MOT_STOP));
    press(B_CLEAR);
    chk("cleared", 32'h0, 32'({aled, rmode}));
    end_sim();
  end
endmodule
